// ==== logic/vin_fault_top.sv ====
// Input voltage limits, fault reaction and PMBus register access
// How it works
// - Over-voltage warning limit word, read/write
// - Under-voltage warning limit word, read/write
// - Under-voltage fault limit word starts reaction
// - Reaction byte: response, retries, delay
// - Any response raises alert and status
// - Code 00 ignores; 01 runs for delay
// - Fault still present after delay: retry
// - Code 10 shuts off, then retries
// - Code 11 off only while fault lasts
// - Zero retries: stay off until cleared
// - One retry, then off until cleared
// - Attempt starts spaced by delay units
// - Codes 010, 011 give two, three tries
// - Codes 100 to 110 give four-six tries
// - Code 111 retries without limit
// - Run-on delay unit is 10 ms
// - Retry spacing unit is 8.2 ms
`timescale 1ns/1ps
`default_nettype none
`include "vin_regs.svh"
module vin_fault_top #(
  parameter int RUN_UNIT_CYC   =
    (`VIN_RUN_UNIT_NS + `VIN_CLK_NS - 1) / `VIN_CLK_NS,
  parameter int RETRY_UNIT_CYC =
    (`VIN_RETRY_UNIT_NS + `VIN_CLK_NS - 1) / `VIN_CLK_NS,
  parameter int CYC_W          = 20
) (
  // System clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // PMBus pins, the clock pin clocks the link
  input  wire logic                 scl_clk,
  input  wire logic                 sda_i,
  output var  logic                 sda_o,
  output var  logic                 sda_oe,
  // Alert pin, open drain
  input  wire logic                 fault_alert_line_i,
  output var  logic                 fault_alert_line_o,
  output var  logic                 fault_alert_line_oe,
  // Input voltage samples, linear format
  input  wire logic [15:0]          vin_sample,
  input  wire logic                 vin_valid,
  // Status flags and power stage
  input  wire logic                 status_clr,
  output var  logic                 uv_fault_flag,
  output var  logic                 uv_warn_flag,
  output var  logic                 ov_warn_flag,
  output var  logic                 out_enable,
  output var  vin_pkg::resp_state_e resp_state
);
  import vin_pkg::*;

  link_if lk ();

  logic             scl_m_q;
  logic             scl_s_q;
  logic             sda_m_q;
  logic             sda_s_q;
  logic             sda_p_q;
  logic             rx_m_q;
  logic             rx_s_q;
  logic             rx_p_q;
  logic             start_tgl_q;
  logic             start_c;
  logic             stop_c;
  logic             byte_evt;
  logic [2:0]       idx_q;
  logic             rw_q;
  logic             match_q;
  logic             rd_hi_q;
  logic [7:0]       cmd_q;
  logic [7:0]       dlo_q;
  logic [7:0]       dhi_q;
  logic [7:0]       tx_q;
  logic [15:0]      rd_word;
  logic             wr_word;
  logic             wr_byte;
  logic [15:0]      ov_warn_lim_q;
  logic [15:0]      uv_warn_lim_q;
  logic [15:0]      uv_fault_lim_q;
  logic [7:0]       react_q;
  logic             uv_c;
  logic             uvw_c;
  logic             ovw_c;
  logic             uv_now_q;
  logic             fault_evt;
  logic             uv_fault_q;
  logic             uv_warn_q;
  logic             ov_warn_q;
  logic             alert_o_q;
  logic             alert_oe_q;
  reaction_e        resp;
  logic [2:0]       retry;
  logic [2:0]       dly;
  resp_state_e      state_q;
  resp_state_e      state_d;
  logic [2:0]       tries_q;
  logic [2:0]       tries_d;
  logic             out_q;
  logic             out_d;
  logic             load_d;
  logic [2:0]       units_q;
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] unit_last;
  logic             tmr_done;

  // Linear word to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] lin_fix(input logic [15:0] w);
    logic [5:0] e;
    e = {w[15], w[15:11]} + 6'h10;
    lin_fix = 48'(signed'(w[10:0])) <<< e[4:0];
  endfunction

  // State entered once the output is shut for retries
  function automatic resp_state_e retry_entry(input logic [2:0] r);
    retry_entry = (r == `VIN_RETRY_NONE) ? ST_LOCKED : ST_SPACING;
  endfunction

  pmbus_link u_link (
    .scl_clk (scl_clk),
    .rst_b   (rst_b),
    .sda_i   (sda_i),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .lk      (lk.link)
  );

  // Pin and toggle synchronisers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      rx_m_q  <= 1'b0;
      rx_s_q  <= 1'b0;
      rx_p_q  <= 1'b0;
    end else begin
      scl_m_q <= scl_clk;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      rx_m_q  <= lk.rx_tgl;
      rx_s_q  <= rx_m_q;
      rx_p_q  <= rx_s_q;
    end
  end

  assign start_c  = scl_s_q && sda_p_q && !sda_s_q;
  assign stop_c   = scl_s_q && !sda_p_q && sda_s_q;
  assign byte_evt = rx_s_q ^ rx_p_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_tgl_q <= 1'b0;
    end else if (start_c) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // Frame decode: address, command, then data or read bytes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      idx_q   <= 3'h0;
      rw_q    <= 1'b0;
      match_q <= 1'b0;
      rd_hi_q <= 1'b0;
      cmd_q   <= 8'h00;
      dlo_q   <= 8'h00;
      dhi_q   <= 8'h00;
    end else if (start_c) begin
      idx_q   <= 3'h0;
      rd_hi_q <= 1'b0;
    end else if (byte_evt) begin
      idx_q <= (idx_q == 3'h7) ? idx_q : idx_q + 3'h1;
      if (idx_q == 3'h0) begin
        match_q <= lk.rx_byte[7:1] == `VIN_DEV_ADDR;
        rw_q    <= lk.rx_byte[0];
      end else if (rw_q) begin
        rd_hi_q <= 1'b1;
      end else if (idx_q == 3'h1) begin
        cmd_q <= lk.rx_byte;
      end else if (idx_q == 3'h2) begin
        dlo_q <= lk.rx_byte;
      end else if (idx_q == 3'h3) begin
        dhi_q <= lk.rx_byte;
      end
    end
  end

  // Writes take effect at the stop, so a cut-short frame changes nothing
  assign wr_word = stop_c && match_q && !rw_q && idx_q == 3'h4;
  assign wr_byte = stop_c && match_q && !rw_q && idx_q == 3'h3;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ov_warn_lim_q  <= `VIN_OV_WARN_RST;
      uv_warn_lim_q  <= `VIN_UV_WARN_RST;
      uv_fault_lim_q <= `VIN_UV_FAULT_RST;
      react_q        <= `VIN_UV_REACT_RST;
    end else if (wr_word) begin
      if (cmd_q == `VIN_OV_WARN_OFS) begin
        ov_warn_lim_q <= {dhi_q, dlo_q};
      end
      if (cmd_q == `VIN_UV_WARN_OFS) begin
        uv_warn_lim_q <= {dhi_q, dlo_q};
      end
      if (cmd_q == `VIN_UV_FAULT_OFS) begin
        uv_fault_lim_q <= {dhi_q, dlo_q};
      end
    end else if (wr_byte && cmd_q == `VIN_UV_REACT_OFS) begin
      react_q <= dlo_q;
    end
  end

  // Read data, low byte first; unknown commands read zero
  always_comb begin
    rd_word = 16'h0000;
    if (cmd_q == `VIN_OV_WARN_OFS) begin
      rd_word = ov_warn_lim_q;
    end
    if (cmd_q == `VIN_UV_WARN_OFS) begin
      rd_word = uv_warn_lim_q;
    end
    if (cmd_q == `VIN_UV_FAULT_OFS) begin
      rd_word = uv_fault_lim_q;
    end
    if (cmd_q == `VIN_UV_REACT_OFS) begin
      rd_word = {8'h00, react_q};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_q <= 8'h00;
    end else begin
      tx_q <= rd_hi_q ? rd_word[15:8] : rd_word[7:0];
    end
  end

  assign lk.tx_byte   = tx_q;
  assign lk.start_tgl = start_tgl_q;

  // Limit comparison on each new sample
  assign uv_c  = lin_fix(vin_sample) < lin_fix(uv_fault_lim_q);
  assign uvw_c = lin_fix(vin_sample) < lin_fix(uv_warn_lim_q);
  assign ovw_c = lin_fix(vin_sample) > lin_fix(ov_warn_lim_q);
  assign fault_evt = vin_valid && uv_c && !uv_now_q;

  // Sticky status; a new crossing beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      uv_now_q   <= 1'b0;
      uv_fault_q <= 1'b0;
      uv_warn_q  <= 1'b0;
      ov_warn_q  <= 1'b0;
    end else begin
      if (vin_valid) begin
        uv_now_q <= uv_c;
      end
      uv_fault_q <= (vin_valid && uv_c) || (uv_fault_q && !status_clr);
      uv_warn_q  <= (vin_valid && uvw_c) || (uv_warn_q && !status_clr);
      ov_warn_q  <= (vin_valid && ovw_c) || (ov_warn_q && !status_clr);
    end
  end

  // Alert is pulled low while any status bit stands
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alert_o_q  <= 1'b0;
      alert_oe_q <= 1'b0;
    end else begin
      alert_o_q  <= 1'b0;
      alert_oe_q <= uv_fault_q || uv_warn_q || ov_warn_q;
    end
  end

  assign resp  = reaction_e'(react_q[`VIN_RESP_HI:`VIN_RESP_LO]);
  assign retry = react_q[`VIN_RETRY_HI:`VIN_RETRY_LO];
  assign dly   = react_q[`VIN_DLY_HI:`VIN_DLY_LO];

  // Fault reaction sequence
  always_comb begin
    state_d = state_q;
    tries_d = tries_q;
    out_d   = out_q;
    load_d  = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        if (fault_evt) begin
          unique case (resp)
            REACT_IGNORE: begin
              out_d = out_q;
            end
            REACT_DELAY: begin
              state_d = ST_DELAY;
              load_d  = 1'b1;
            end
            REACT_RETRY: begin
              out_d   = 1'b0;
              tries_d = retry;
              state_d = retry_entry(retry);
              load_d  = 1'b1;
            end
            REACT_CLEAR: begin
              out_d   = 1'b0;
              state_d = ST_HOLD;
            end
          endcase
        end
      end
      ST_DELAY: begin
        if (tmr_done && uv_now_q) begin
          out_d   = 1'b0;
          tries_d = retry;
          state_d = retry_entry(retry);
          load_d  = 1'b1;
        end else if (tmr_done) begin
          state_d = ST_RUN;
        end
      end
      ST_SPACING: begin
        if (tmr_done) begin
          out_d   = 1'b1;
          state_d = ST_ATTEMPT;
          load_d  = 1'b1;
        end
      end
      ST_ATTEMPT: begin
        if (vin_valid && !uv_c) begin
          state_d = ST_RUN;
        end else if (vin_valid) begin
          out_d = 1'b0;
          if (tries_q == `VIN_RETRY_FOREVER) begin
            state_d = ST_SPACING;
          end else if (tries_q == 3'h1) begin
            state_d = ST_LOCKED;
          end else begin
            tries_d = tries_q - 3'h1;
            state_d = ST_SPACING;
          end
        end
      end
      ST_LOCKED: begin
        if (status_clr && !uv_now_q) begin
          out_d   = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (vin_valid && !uv_c) begin
          out_d   = 1'b1;
          state_d = ST_RUN;
        end
      end
      default: begin
        out_d   = 1'b0;
        state_d = ST_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      tries_q <= 3'h0;
      out_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      tries_q <= tries_d;
      out_q   <= out_d;
    end
  end

  // Spacing is timed from the start of an attempt, not from its failure
  assign unit_last = (state_q == ST_DELAY) ?
                     CYC_W'(RUN_UNIT_CYC - 1) :
                     CYC_W'(RETRY_UNIT_CYC - 1);
  assign tmr_done  = units_q == 3'h0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      units_q <= 3'h0;
      cyc_q   <= '0;
    end else if (load_d) begin
      units_q <= dly;
      cyc_q   <= '0;
    end else if (!tmr_done && cyc_q == unit_last) begin
      units_q <= units_q - 3'h1;
      cyc_q   <= '0;
    end else if (!tmr_done) begin
      cyc_q <= cyc_q + CYC_W'(1);
    end
  end

  assign fault_alert_line_o  = alert_o_q;
  assign fault_alert_line_oe = alert_oe_q;
  assign uv_fault_flag       = uv_fault_q;
  assign uv_warn_flag        = uv_warn_q;
  assign ov_warn_flag        = ov_warn_q;
  assign out_enable          = out_q;
  assign resp_state          = state_q;

  a_word_commit: assert property (@(posedge clk) disable iff (!rst_b)
    wr_word && cmd_q == `VIN_OV_WARN_OFS
    |=> ov_warn_lim_q == {$past(dhi_q), $past(dlo_q)})
    else $error("over-voltage warning limit not written");

  a_react_commit: assert property (@(posedge clk) disable iff (!rst_b)
    wr_byte && cmd_q == `VIN_UV_REACT_OFS |=> react_q == $past(dlo_q))
    else $error("reaction byte not written");

  a_fault_alert: assert property (@(posedge clk) disable iff (!rst_b)
    vin_valid && uv_c |=> uv_fault_q ##1 fault_alert_line_oe)
    else $error("fault sample did not raise status and alert");

  a_ignore_runs: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_RUN && fault_evt && resp == REACT_IGNORE && out_q
    |=> out_q && state_q == ST_RUN)
    else $error("ignore response disturbed the output");

  a_retry_shut: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_RUN && fault_evt && resp == REACT_RETRY
    |=> !out_enable && tries_q == $past(retry))
    else $error("retry response did not shut the output");

  a_hold_release: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_HOLD && vin_valid && !uv_c
    |=> out_enable && state_q == ST_RUN)
    else $error("output not restored after fault cleared");

  a_zero_lock: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_RUN && fault_evt && resp == REACT_RETRY
    && retry == `VIN_RETRY_NONE |=> state_q == ST_LOCKED && !out_q)
    else $error("zero retries did not lock off");

  a_locked_off: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_LOCKED && !(status_clr && !uv_now_q)
    |=> state_q == ST_LOCKED && !out_enable)
    else $error("locked state left or output on");

  a_spacing_load: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_SPACING && tmr_done
    |=> state_q == ST_ATTEMPT && out_q && units_q == $past(dly))
    else $error("attempt did not start with a fresh interval");

  a_forever_kept: assert property (@(posedge clk) disable iff (!rst_b)
    tries_q == `VIN_RETRY_FOREVER
    && state_q inside {ST_SPACING, ST_ATTEMPT}
    |=> tries_q == `VIN_RETRY_FOREVER)
    else $error("unlimited retry count changed");

  a_unit_step: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_DELAY && !tmr_done && cyc_q == CYC_W'(RUN_UNIT_CYC - 1)
    |=> units_q == $past(units_q) - 3'h1 && cyc_q == '0)
    else $error("delay unit not counted down");
endmodule
`default_nettype wire

// ==== include/vin_regs.svh ====
// Offsets, field positions, reset values and timing of the input monitor
`ifndef VIN_REGS_SVH
`define VIN_REGS_SVH

`define VIN_OV_WARN_OFS    8'h57
`define VIN_UV_WARN_OFS    8'h58
`define VIN_UV_FAULT_OFS   8'h59
`define VIN_UV_REACT_OFS   8'h5A

`define VIN_OV_WARN_RST    16'hF81D
`define VIN_UV_WARN_RST    16'hF809
`define VIN_UV_FAULT_RST   16'hF808
`define VIN_UV_REACT_RST   8'hC0

`define VIN_RESP_HI        7
`define VIN_RESP_LO        6
`define VIN_RETRY_HI       5
`define VIN_RETRY_LO       3
`define VIN_DLY_HI         2
`define VIN_DLY_LO         0
`define VIN_RETRY_NONE     3'h0
`define VIN_RETRY_FOREVER  3'h7

`define VIN_DEV_ADDR       7'h24

`define VIN_CLK_NS         20
`define VIN_RUN_UNIT_NS    10000000
`define VIN_RETRY_UNIT_NS  8200000

`endif

// ==== include/vin_pkg.sv ====
// Types shared by the input voltage fault response block
`default_nettype none
package vin_pkg;

  typedef enum logic [1:0] {
    REACT_IGNORE,
    REACT_DELAY,
    REACT_RETRY,
    REACT_CLEAR
  } reaction_e;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DELAY,
    ST_SPACING,
    ST_ATTEMPT,
    ST_LOCKED,
    ST_HOLD
  } resp_state_e;

endpackage
`default_nettype wire

// ==== include/link_if.sv ====
// Byte exchange between the serial link domain and the core domain
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic [7:0] rx_byte;
  logic       rx_tgl;
  logic       start_tgl;
  logic [7:0] tx_byte;

  modport core (
    input  rx_byte,
    input  rx_tgl,
    output start_tgl,
    output tx_byte
  );

  modport link (
    output rx_byte,
    output rx_tgl,
    input  start_tgl,
    input  tx_byte
  );
endinterface
`default_nettype wire

// ==== logic/pmbus_link.sv ====
// Serial byte engine running on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "vin_regs.svh"
module pmbus_link (
  // Link clock and core reset
  input  wire logic scl_clk,
  input  wire logic rst_b,
  // Data pin, open drain
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe,
  // Bytes to and from the core
  link_if.link      lk
);
  logic       rs1_q;
  logic       rs_q;
  logic       st1_q;
  logic       st2_q;
  logic       st_seen_q;
  logic       first_q;
  logic       match_q;
  logic       xmit_q;
  logic       ack_q;
  logic       rx_tgl_q;
  logic [3:0] bit_q;
  logic [6:0] sh_q;
  logic [7:0] rx_q;
  logic       sda_o_q;
  logic       sda_oe_q;
  logic       new_frame;

  // Core reset and start toggle enter this domain through two flops
  always_ff @(posedge scl_clk) begin
    rs1_q <= rst_b;
    rs_q  <= rs1_q;
    st1_q <= lk.start_tgl;
    st2_q <= st1_q;
  end

  assign new_frame = st2_q != st_seen_q;

  // A start reaches this domain two rises late, while the third bit is
  // taken, so the slot count is realigned there. Shifting on every rise
  // keeps the two early bits. The start must settle before the first rise.
  always_ff @(posedge scl_clk) begin
    if (!rs_q) begin
      bit_q     <= 4'h0;
      sh_q      <= 7'h00;
      rx_q      <= 8'h00;
      rx_tgl_q  <= 1'b0;
      st_seen_q <= 1'b0;
      first_q   <= 1'b0;
      match_q   <= 1'b0;
      xmit_q    <= 1'b0;
      ack_q     <= 1'b0;
    end else begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      sh_q  <= {sh_q[5:0], sda_i};
      if (new_frame) begin
        st_seen_q <= st2_q;
        first_q   <= 1'b1;
        bit_q     <= 4'h3;
      end
      if (bit_q == 4'h7) begin
        rx_q     <= {sh_q, sda_i};
        rx_tgl_q <= ~rx_tgl_q;
        if (first_q || new_frame) begin
          first_q <= 1'b0;
          match_q <= sh_q == `VIN_DEV_ADDR;
          ack_q   <= sh_q == `VIN_DEV_ADDR;
          xmit_q  <= sda_i;
        end else begin
          ack_q <= match_q && !xmit_q;
        end
      end
      // Master not-acknowledge ends a read
      if (bit_q == 4'h8 && xmit_q && sda_i) begin
        xmit_q <= 1'b0;
      end
    end
  end

  // Pin changes only while the clock is low
  always_ff @(negedge scl_clk) begin
    if (!rs_q) begin
      sda_o_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bit_q == 4'h8) begin
      sda_o_q  <= 1'b0;
      sda_oe_q <= ack_q;
    end else if (xmit_q && match_q) begin
      sda_o_q  <= lk.tx_byte[3'(4'h7 - bit_q)];
      sda_oe_q <= !lk.tx_byte[3'(4'h7 - bit_q)];
    end else begin
      sda_o_q  <= 1'b0;
      sda_oe_q <= 1'b0;
    end
  end

  assign sda_o      = sda_o_q;
  assign sda_oe     = sda_oe_q;
  assign lk.rx_byte = rx_q;
  assign lk.rx_tgl  = rx_tgl_q;
endmodule
`default_nettype wire

// ==== tb/pmbus_host.sv ====
// PMBus host model: bit-level master on the clock and data pins
`timescale 1ns/1ps
`default_nettype none
`include "vin_regs.svh"
module pmbus_host (
  // Bus pins
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Clock runs only in reset and in frames
  task automatic tick(input int n);
    repeat (n) begin
      #32 scl = 1'b0;
      #32 scl = 1'b1;
    end
  endtask
  // Long high phase so the core domain sees the edge
  // Data moves early in the low phase so the core never takes it for a
  // start or stop
  task automatic start();
    scl = 1'b0;
    #8 sda_low = 1'b0;
    #24 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100;
  endtask
  task automatic stop();
    scl = 1'b0;
    #8 sda_low = 1'b1;
    #24 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #8 sda_low = ~b;
    #24 scl = 1'b1;
    r = sda;
    #32;
  endtask
  // Ninth slot: last high releases the wire
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, nak);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v,
                    input bit word, output logic nak);
    logic [7:0] q;
    logic [3:0] n;
    n = 4'h0;
    start();
    xfer({`VIN_DEV_ADDR, 1'b0}, 1'b1, q, n[0]);
    xfer(cmd, 1'b1, q, n[1]);
    xfer(v[7:0], 1'b1, q, n[2]);
    if (word) xfer(v[15:8], 1'b1, q, n[3]);
    stop();
    nak = |n;
  endtask
  task automatic rd(input logic [7:0] cmd, input bit word,
                    output logic [15:0] v);
    logic [7:0] q;
    logic       n;
    v = 16'h0000;
    start();
    xfer({`VIN_DEV_ADDR, 1'b0}, 1'b1, q, n);
    xfer(cmd, 1'b1, q, n);
    start();
    xfer({`VIN_DEV_ADDR, 1'b1}, 1'b1, q, n);
    xfer(8'hFF, ~word, v[7:0], n);
    if (word) xfer(8'hFF, 1'b1, v[15:8], n);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_input_voltage_fault_response.sv ====
// Self-checking bench for the input voltage fault response block
`timescale 1ns/1ps
`default_nettype none
`include "vin_regs.svh"
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); \
  end \
end
module tb_input_voltage_fault_response;
  import vin_pkg::*;
  localparam int          RUN  = 50;
  localparam int          RTY  = 41;
  localparam logic [15:0] LOW  = 16'hF805;
  localparam logic [15:0] GOOD = 16'hF810;
  localparam logic [15:0] HIGH = 16'hF820;
  localparam logic [7:0]  OFS [4] = '{`VIN_OV_WARN_OFS, `VIN_UV_WARN_OFS,
                                      `VIN_UV_FAULT_OFS, `VIN_UV_REACT_OFS};
  localparam logic [15:0] RST [4] = '{`VIN_OV_WARN_RST, `VIN_UV_WARN_RST,
                                      `VIN_UV_FAULT_RST,
                                      {8'h00, `VIN_UV_REACT_RST}};
  logic        clk        = 1'b0;
  logic        rst_b      = 1'b0;
  logic [15:0] vin_sample = 16'h0000;
  logic        vin_valid  = 1'b0;
  logic        status_clr = 1'b0;
  logic        scl, sda_low, sda_o, sda_oe, sda, al_o, al_oe, al;
  logic        uv_fault_flag, uv_warn_flag, ov_warn_flag, out_enable;
  resp_state_e resp_state;
  logic [31:0] seed       = 32'hAA601723;
  int          fail_count  = 0;
  int          comparisons = 0;

  always #10 clk = ~clk;
  // Open-drain wires with pull-ups
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  assign al  = ~(al_oe & ~al_o);

  vin_fault_top #(.RUN_UNIT_CYC(RUN), .RETRY_UNIT_CYC(RTY)) u_dut (
    .clk(clk), .rst_b(rst_b), .scl_clk(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .fault_alert_line_i(al),
    .fault_alert_line_o(al_o), .fault_alert_line_oe(al_oe),
    .vin_sample(vin_sample), .vin_valid(vin_valid),
    .status_clr(status_clr), .uv_fault_flag(uv_fault_flag),
    .uv_warn_flag(uv_warn_flag), .ov_warn_flag(ov_warn_flag),
    .out_enable(out_enable), .resp_state(resp_state));
  pmbus_host u_host (.scl(scl), .sda_low(sda_low), .sda(sda));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Unlimited retries are judged after eight attempts
  function automatic int tries(input logic [2:0] r);
    return (r == `VIN_RETRY_FOREVER) ? 8 : int'(r);
  endfunction

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic sample(input logic [15:0] v);
    @(posedge clk);
    vin_sample <= v;
    vin_valid <= 1'b1;
    @(posedge clk);
    vin_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_en(input logic t, input int lim, output int n);
    n = 0;
    while (out_enable !== t && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic setup(input logic [7:0] r);
    logic nak;
    u_host.wr(`VIN_UV_REACT_OFS, {8'h00, r}, 1'b0, nak);
    repeat (6) @(posedge clk);
    `CHK(nak, 1'b0)
  endtask
  // Clearing with the fault gone releases any lock
  task automatic recover();
    int n;
    sample(GOOD);
    @(posedge clk);
    status_clr <= 1'b1;
    @(posedge clk);
    status_clr <= 1'b0;
    wait_en(1'b1, 10, n);
    repeat (2) @(posedge clk);
    #1;
    `CHK({out_enable, uv_fault_flag, al_oe}, 3'b100)
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    logic [15:0] v, w;
    logic        nak;
    logic [2:0]  d;
    int          n, a;
    u_host.tick(4);
    @(posedge clk);
    rst_b <= 1'b1;
    // Link side leaves reset only on clock rises
    u_host.tick(2);
    repeat (5) @(posedge clk);
    #1;
    `CHK({out_enable, al_oe, uv_fault_flag}, 3'b100)
    for (int i = 0; i < 4; i++) begin
      u_host.rd(OFS[i], i < 3, v);
      `CHK(v, RST[i])
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(lfsr(seed));
      w = (i < 3) ? seed[15:0] : {8'h00, seed[7:0]};
      u_host.wr(OFS[i], w, i < 3, nak);
      repeat (6) @(posedge clk);
      u_host.rd(OFS[i], i < 3, v);
      `CHK({nak, v}, {1'b0, w})
      if (i < 3) u_host.wr(OFS[i], RST[i], 1'b1, nak);
    end
    repeat (6) @(posedge clk);
    sample(HIGH);
    `CHK({ov_warn_flag, uv_warn_flag, uv_fault_flag}, 3'b100)
    @(posedge clk);
    #1;
    `CHK({al_oe, al}, 2'b10)
    recover();
    setup(8'h3F);
    seed = lfsr(seed);
    sample({13'h1F00, seed[2:0]});
    `CHK({uv_fault_flag, uv_warn_flag}, 2'b11)
    repeat (20) @(posedge clk);
    #1;
    `CHK({out_enable, al_oe}, 2'b11)
    recover();
    setup(8'h42);
    sample(LOW);
    `CHK(resp_state, ST_DELAY)
    wait_en(1'b0, 200, n);
    `CHK(n >= 2 * RUN - 4 && n <= 2 * RUN + 4, 1'b1)
    `CHK(resp_state, ST_LOCKED)
    sample(GOOD);
    `CHK(out_enable, 1'b0)
    recover();
    setup(8'h41);
    sample(LOW);
    sample(GOOD);
    wait_en(1'b0, RUN + 20, n);
    `CHK(out_enable, 1'b1)
    recover();
    for (int r = 0; r < 8; r++) begin
      d = 3'((r % 2) + 1);
      setup({2'b10, r[2:0], d});
      sample(LOW);
      `CHK(out_enable, 1'b0)
      a = 0;
      wait_en(1'b1, d * RTY + 6, n);
      while (out_enable === 1'b1 && a < 8) begin
        `CHK(n >= d * RTY - 4 && n <= d * RTY + 4, 1'b1)
        a++;
        sample(LOW);
        wait_en(1'b1, d * RTY + 6, n);
      end
      `CHK(a, tries(r[2:0]))
      if (r == 7) sample(GOOD);
      repeat (3) @(posedge clk);
      #1;
      `CHK(out_enable, r == 7)
      recover();
    end
    setup(8'hC0);
    sample(LOW);
    `CHK(out_enable, 1'b0)
    sample(LOW);
    `CHK({out_enable, uv_fault_flag}, 2'b01)
    sample(GOOD);
    wait_en(1'b1, 4, n);
    `CHK(out_enable, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
